// >>> rtl/cm_host_pkg.sv
package cm_host_pkg;
    localparam int           DATA_W        = 16;
    localparam int           ADDR_W        = 15;
    localparam int           MEM_WORDS     = 4096;
    localparam int           MEM_AW        = 12;
    localparam int           CLK_MHZ       = 50;
    localparam int           BLOCK_MAX_US  = 125;
    localparam int           BLOCK_MAX_CYC = BLOCK_MAX_US * CLK_MHZ;
    localparam int           SEL_BIT       = 14;
    localparam int           SRC_BIT       = 15;
    localparam int           MSG_BIT       = 14;
    localparam int           OE_BIT        = 13;
    localparam logic [2:0]   MS_LOCAL_CM   = 3'h0;
    localparam logic [2:0]   MS_BACK_CM    = 3'h1;
    localparam logic [2:0]   MS_LOCAL_DM   = 3'h2;
    localparam logic [2:0]   MS_BACK_DM    = 3'h3;
    localparam logic [2:0]   PATTERN_RST   = 3'h0;
    localparam logic [15:0]  WORD_RST      = 16'h0000;

    typedef struct packed {
        logic        sel;
        logic [4:0]  stream;
        logic [8:0]  channel;
    } host_addr_t;

    typedef struct packed {
        logic        src_side;
        logic        msg_mode;
        logic        out_en;
        logic [12:0] body;
    } conn_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_ACK  = 2'b11,
        ST_WAIT = 2'b10
    } bus_state_t;
endpackage

// >>> rtl/sync2.sv
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] out_nxt;

    always_comb begin
        meta_nxt = din;
        out_nxt  = meta_r;
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        dout   <= out_nxt;
    end
endmodule

// >>> rtl/conn_mem.sv
module conn_mem #(
    parameter int WORDS = 4096,
    parameter int AW    = 12
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [15:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [15:0]        rdata
);
    logic [15:0] mem_r [WORDS];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
        rdata <= mem_r[raddr];
    end
endmodule

// >>> rtl/connection_memory_host_port.sv
module connection_memory_host_port #(
    parameter int BLOCK_MAX_CYC = cm_host_pkg::BLOCK_MAX_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cs_n,
    input  wire logic        ds_n,
    input  wire logic        rd_wr_n,
    input  wire logic [14:0] addr,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic             rdata_oe,
    output logic             data_transfer_ack_n,
    output logic             data_transfer_ack_oe,
    input  wire logic        switch_clock_ok,
    input  wire logic [2:0]  memory_select,
    input  wire logic        block_mode_bit,
    input  wire logic        block_program_enable,
    input  wire logic [2:0]  local_block_pattern,
    input  wire logic [2:0]  backplane_block_pattern,
    output logic             block_program_done,
    input  wire logic        local_32m,
    input  wire logic        backplane_32m,
    input  wire logic [7:0]  local_data_word,
    input  wire logic [7:0]  backplane_data_word,
    output logic [11:0]      data_mem_addr,
    input  wire logic [11:0] local_out_index,
    input  wire logic [11:0] backplane_out_index,
    output logic [15:0]      local_conn_word,
    output logic [15:0]      backplane_conn_word,
    input  wire logic        output_drive_enable_pin,
    input  wire logic        local_output_reset_state,
    input  wire logic        backplane_output_reset_state,
    output logic [1:0]       local_ext_buffer_ctrl,
    output logic [1:0]       backplane_ext_buffer_ctrl,
    output logic             local_serial_idle_high,
    output logic             local_serial_idle_oe,
    output logic             backplane_serial_idle_high,
    output logic             backplane_serial_idle_oe
);
    // sized from the module parameter so a longer bound cannot wrap the fill counter
    localparam int CW = $clog2(BLOCK_MAX_CYC + 1);

    // async assert, synchronous release
    logic rst_a_r, rst_b_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end
    wire logic rst_ok = rst_b_r;

    // host pins are asynchronous
    logic [19:0] pin_s;
    sync2 #(.W(20)) u_pins (
        .clk  (clk),
        .din  ({cs_n, ds_n, rd_wr_n, output_drive_enable_pin, local_output_reset_state,
                backplane_output_reset_state, block_mode_bit, block_program_enable,
                local_block_pattern, backplane_block_pattern, memory_select, switch_clock_ok, 2'b00}),
        .dout (pin_s)
    );
    wire logic       cs_s  = ~pin_s[19];
    wire logic       ds_s  = ~pin_s[18];
    wire logic       rd_s  = pin_s[17];
    wire logic       ode_s = pin_s[16];
    wire logic       local_output_reset_state_s = pin_s[15];
    wire logic       backplane_output_reset_state_s = pin_s[14];
    wire logic       mbp_s = pin_s[13];
    wire logic       bpe_s = pin_s[12];
    wire logic [2:0] lpat_s = pin_s[11:9];
    wire logic [2:0] bpat_s = pin_s[8:6];
    wire logic [2:0] ms_s  = pin_s[5:3];
    wire logic       clk_ok_s = pin_s[2];

    // address and write data cross with the strobes, so all arrive in the same cycle;
    // the host holds them steady around the strobe, so a plain two-flop crossing does not tear
    logic [30:0] bus_s;
    sync2 #(.W(31)) u_bus (
        .clk  (clk),
        .din  ({addr, wdata}),
        .dout (bus_s)
    );
    wire logic [14:0] addr_s  = bus_s[30:16];
    wire logic [15:0] wdata_s = bus_s[15:0];

    // block programming engine
    logic        blk_act_r, blk_act_nxt;
    logic        done_r, done_nxt;
    logic [11:0] blk_idx_r, blk_idx_nxt;
    logic [CW-1:0] blk_cnt_r, blk_cnt_nxt;
    wire logic blk_go = mbp_s && bpe_s;

    always_comb begin
        blk_act_nxt = blk_act_r;
        blk_idx_nxt = blk_idx_r;
        done_nxt    = done_r;
        blk_cnt_nxt = blk_cnt_r;
        if (!blk_go) begin
            blk_act_nxt = 1'b0;
            done_nxt    = 1'b0;
            blk_idx_nxt = '0;
            blk_cnt_nxt = '0;
        end else if (!blk_act_r && !done_r) begin
            blk_act_nxt = 1'b1;
        end else if (blk_act_r) begin
            blk_idx_nxt = blk_idx_r + 12'h001;
            blk_cnt_nxt = blk_cnt_r + 1'b1;
            // the bound stops a fill that runs long, so the host never waits forever
            if (blk_idx_r == 12'hFFF || int'(blk_cnt_r) >= BLOCK_MAX_CYC - 1) begin
                blk_act_nxt = 1'b0;
                done_nxt    = 1'b1;
            end
        end
    end

    // host access state machine
    cm_host_pkg::bus_state_t st_r, st_nxt;
    logic [15:0] rdata_nxt;
    logic        rd_oe_nxt, ack_nxt;
    logic        host_we_l, host_we_b;
    cm_host_pkg::host_addr_t ha;
    logic [15:0] lcm_q, bcm_q;

    always_comb begin
        ha        = addr_s;
        st_nxt    = st_r;
        rdata_nxt = rdata;
        rd_oe_nxt = 1'b0;
        ack_nxt   = 1'b0;
        host_we_l = 1'b0;
        host_we_b = 1'b0;
        unique case (st_r)
            cm_host_pkg::ST_IDLE: begin
                if (cs_s && ds_s) begin
                    st_nxt = cm_host_pkg::ST_BUSY;
                    if (!rd_s && ha.sel && clk_ok_s) begin
                        host_we_l = (ms_s == cm_host_pkg::MS_LOCAL_CM);
                        host_we_b = (ms_s == cm_host_pkg::MS_BACK_CM);
                    end
                end
            end
            cm_host_pkg::ST_BUSY: begin
                // memory read data is ready here; undefined without clock
                st_nxt = cm_host_pkg::ST_ACK;
                if (!ha.sel) begin
                    rdata_nxt = 16'h0000;
                end else begin
                    unique case (ms_s)
                        cm_host_pkg::MS_LOCAL_CM: rdata_nxt = lcm_q;
                        cm_host_pkg::MS_BACK_CM:  rdata_nxt = bcm_q;
                        cm_host_pkg::MS_LOCAL_DM: rdata_nxt = {8'h00, local_data_word};
                        cm_host_pkg::MS_BACK_DM:  rdata_nxt = {8'h00, backplane_data_word};
                        default:                  rdata_nxt = 16'h0000;
                    endcase
                end
                rd_oe_nxt = rd_s;
                ack_nxt   = 1'b1;
            end
            cm_host_pkg::ST_ACK: begin
                rd_oe_nxt = rd_s;
                ack_nxt   = 1'b1;
                if (!(cs_s && ds_s)) begin
                    st_nxt = cm_host_pkg::ST_WAIT;
                end
            end
            cm_host_pkg::ST_WAIT: begin
                st_nxt = cm_host_pkg::ST_IDLE;
            end
        endcase
    end

    // address 13:9 stream, 8:0 channel; fold to 12-bit word index
    function automatic logic [11:0] mem_index(input logic [4:0] s, input logic [8:0] c, input logic is32);
        mem_index = is32 ? {s[2:0], c} : {s[3:0], c[7:0]};
    endfunction

    wire logic [11:0] lidx = mem_index(ha.stream, ha.channel, local_32m);
    wire logic [11:0] bidx = mem_index(ha.stream, ha.channel, backplane_32m);
    wire logic [15:0] lfill = {lpat_s, 13'h0000};
    wire logic [15:0] bfill = {bpat_s, 13'h0000};
    logic        lcm_re_sel;
    logic [11:0] dm_addr_nxt;

    conn_mem #(.WORDS(cm_host_pkg::MEM_WORDS), .AW(cm_host_pkg::MEM_AW)) u_lcm (
        .clk   (clk),
        .we    (blk_act_r || (host_we_l && rst_ok)),
        .waddr (blk_act_r ? blk_idx_r : lidx),
        .wdata (blk_act_r ? lfill : wdata_s),
        .raddr (lcm_re_sel ? lidx : local_out_index),
        .rdata (lcm_q)
    );
    conn_mem #(.WORDS(cm_host_pkg::MEM_WORDS), .AW(cm_host_pkg::MEM_AW)) u_bcm (
        .clk   (clk),
        .we    (blk_act_r || (host_we_b && rst_ok)),
        .waddr (blk_act_r ? blk_idx_r : bidx),
        .wdata (blk_act_r ? bfill : wdata_s),
        .raddr (lcm_re_sel ? bidx : backplane_out_index),
        .rdata (bcm_q)
    );

    // host read shares the port with the switch scan; host wins in the take cycle only,
    // so the scan word shows one foreign word per host access
    assign lcm_re_sel = (st_r == cm_host_pkg::ST_IDLE) && cs_s && ds_s;

    // data memory address is held from the take, so the read word stays put after release
    always_comb begin
        dm_addr_nxt = data_mem_addr;
        if (lcm_re_sel) begin
            dm_addr_nxt = (ms_s == cm_host_pkg::MS_BACK_DM) ? bidx : lidx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_ok) begin
            st_r                 <= cm_host_pkg::ST_IDLE;
            rdata                <= cm_host_pkg::WORD_RST;
            rdata_oe             <= 1'b0;
            data_transfer_ack_n  <= 1'b1;
            data_transfer_ack_oe <= 1'b0;
            blk_act_r            <= 1'b0;
            done_r               <= 1'b0;
            blk_idx_r            <= '0;
            blk_cnt_r            <= '0;
            block_program_done   <= 1'b0;
            data_mem_addr        <= '0;
            local_conn_word      <= cm_host_pkg::WORD_RST;
            backplane_conn_word  <= cm_host_pkg::WORD_RST;
        end else begin
            st_r                 <= st_nxt;
            rdata                <= rdata_nxt;
            rdata_oe             <= rd_oe_nxt;
            data_transfer_ack_n  <= ~ack_nxt;
            data_transfer_ack_oe <= ack_nxt;
            blk_act_r            <= blk_act_nxt;
            done_r               <= done_nxt;
            blk_idx_r            <= blk_idx_nxt;
            blk_cnt_r            <= blk_cnt_nxt;
            block_program_done   <= done_nxt;
            data_mem_addr        <= dm_addr_nxt;
            local_conn_word      <= lcm_q;
            backplane_conn_word  <= bcm_q;
        end
    end

    // output idle control: reset or drive enable low forces idle
    logic       force_l_nxt, force_b_nxt;
    logic [1:0] lbuf_nxt, bbuf_nxt;
    logic       loe_nxt, boe_nxt;

    always_comb begin
        force_l_nxt = !rst_ok || !ode_s;
        force_b_nxt = !rst_ok || !ode_s;
        lbuf_nxt    = force_l_nxt ? 2'b00 : 2'b11;
        bbuf_nxt    = force_b_nxt ? 2'b00 : 2'b11;
        loe_nxt     = force_l_nxt && local_output_reset_state_s;
        boe_nxt     = force_b_nxt && backplane_output_reset_state_s;
    end

    always_ff @(posedge clk) begin
        local_ext_buffer_ctrl      <= lbuf_nxt;
        backplane_ext_buffer_ctrl  <= bbuf_nxt;
        local_serial_idle_high     <= force_l_nxt;
        local_serial_idle_oe       <= loe_nxt;
        backplane_serial_idle_high <= force_b_nxt;
        backplane_serial_idle_oe   <= boe_nxt;
    end
endmodule

// >>> verification/cm_host_props.sv
module cm_host_props #(
    parameter int BLOCK_MAX_CYC = 6250
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       cs_n,
    input wire logic       ds_n,
    input wire logic       rd_wr_n,
    input wire logic       rdata_oe,
    input wire logic       data_transfer_ack_n,
    input wire logic       data_transfer_ack_oe,
    input wire logic       block_mode_bit,
    input wire logic       block_program_enable,
    input wire logic       block_program_done,
    input wire logic       output_drive_enable_pin,
    input wire logic       local_output_reset_state,
    input wire logic [1:0] local_ext_buffer_ctrl,
    input wire logic       local_serial_idle_high,
    input wire logic       local_serial_idle_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // fill length; restarts whenever the fill stops for any reason
    int blk_cnt;
    always_ff @(posedge clk) begin
        if (!reset_n || !block_mode_bit || !block_program_enable || block_program_done) begin
            blk_cnt <= 0;
        end else begin
            blk_cnt <= blk_cnt + 1;
        end
    end
    chk_ack_answer: assert property (($fell(ds_n) && !cs_n) |-> ##[3:8] !data_transfer_ack_n)
        else $error("acknowledge missing after strobe");
    chk_ack_hold: assert property ((!data_transfer_ack_n && !cs_n && !ds_n) |=> !data_transfer_ack_n)
        else $error("acknowledge dropped while strobe held");
    chk_ack_release: assert property ($rose(ds_n) |-> ##[1:6] data_transfer_ack_n)
        else $error("acknowledge stuck after strobe release");
    chk_ack_driven: assert property (!data_transfer_ack_n |-> data_transfer_ack_oe)
        else $error("acknowledge low but not driven");
    chk_read_drive: assert property ($rose(rdata_oe) |-> rd_wr_n && !cs_n)
        else $error("data bus driven outside a read");
    chk_fill_bound: assert property (blk_cnt <= BLOCK_MAX_CYC)
        else $error("block fill overran its bound");
    chk_fill_whole: assert property ($rose(block_program_done) |-> blk_cnt >= 4090)
        else $error("block fill ended too early");
    chk_fill_abort: assert property ((!block_mode_bit || !block_program_enable) [*4] |-> !block_program_done)
        else $error("fill done without both enables");
    chk_drive_off: assert property ((!output_drive_enable_pin && $stable(local_output_reset_state)) [*5]
        |-> local_ext_buffer_ctrl == 2'h0 && local_serial_idle_high
            && local_serial_idle_oe == local_output_reset_state)
        else $error("outputs not idle while drive disabled");
    chk_drive_on: assert property (output_drive_enable_pin [*5] |-> local_ext_buffer_ctrl == 2'h3
        && !local_serial_idle_high)
        else $error("outputs idle while drive enabled");
    cov_fill: cover property ($rose(block_program_done));
    cov_ack: cover property ($fell(data_transfer_ack_n) && !rd_wr_n);
    cov_drive: cover property ($rose(output_drive_enable_pin));
endmodule

bind connection_memory_host_port cm_host_props #(.BLOCK_MAX_CYC(BLOCK_MAX_CYC)) cm_host_props_i (
    .clk, .reset_n, .cs_n, .ds_n, .rd_wr_n, .rdata_oe, .data_transfer_ack_n, .data_transfer_ack_oe,
    .block_mode_bit, .block_program_enable, .block_program_done, .output_drive_enable_pin,
    .local_output_reset_state, .local_ext_buffer_ctrl, .local_serial_idle_high, .local_serial_idle_oe);

// >>> verification/cm_host_cpu.sv
module cm_host_cpu (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    input  wire logic        ack_n,
    input  wire logic        ack_oe,
    output logic             cs_n,
    output logic             ds_n,
    output logic             rd_wr_n,
    output logic [14:0]      addr,
    output logic [15:0]      wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_w;
    // open-drain acknowledge with a pull-up
    assign ack_w = ack_oe ? ack_n : 1'b1;
    initial begin
        {cs_n, ds_n, rd_wr_n, addr, wdata} = '1;
    end
    // entered just after a rising edge; request held until acknowledge is sampled
    task automatic access(input logic r, input logic [14:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        int n;
        ok = 1'b0;
        {cs_n, ds_n, rd_wr_n, addr, wdata} <= {2'b00, r, a, d};
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = !ack_w;
        end
        q = rdata;
        // released bus must not keep showing the old value
        {cs_n, ds_n, addr, wdata} <= {2'b11, ~a, ~d};
        @(posedge clk);
        for (n = 0; n < 20 && !ack_w; n++) @(posedge clk);
        @(posedge clk);
    endtask
endmodule

// >>> verification/connection_memory_host_port_test.sv
module connection_memory_host_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, reset_n = 1'b0, switch_clock_ok = 1'b1, block_mode_bit = 1'b0;
    logic        block_program_enable = 1'b0, output_drive_enable_pin = 1'b0;
    logic        local_output_reset_state = 1'b0, backplane_output_reset_state = 1'b0;
    logic        cs_n, ds_n, rd_wr_n, rdata_oe, data_transfer_ack_n, data_transfer_ack_oe, block_program_done;
    logic        local_serial_idle_high, local_serial_idle_oe, backplane_serial_idle_high, backplane_serial_idle_oe;
    logic [2:0]  memory_select = 3'h0, local_block_pattern = 3'h0, backplane_block_pattern = 3'h0;
    logic [7:0]  local_data_word = 8'h00, backplane_data_word = 8'h00;
    logic [11:0] local_out_index = 12'h000, backplane_out_index = 12'h000, data_mem_addr;
    logic [14:0] addr;
    logic [15:0] wdata, rdata, local_conn_word, backplane_conn_word;
    logic [1:0]  local_ext_buffer_ctrl, backplane_ext_buffer_ctrl;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #10 clk = ~clk;
    connection_memory_host_port #(.BLOCK_MAX_CYC(5000)) connection_memory_host_port_i (
        .clk, .reset_n, .cs_n, .ds_n, .rd_wr_n, .addr, .wdata, .rdata, .rdata_oe, .data_transfer_ack_n,
        .data_transfer_ack_oe, .switch_clock_ok, .memory_select, .block_mode_bit, .block_program_enable,
        .local_block_pattern, .backplane_block_pattern, .block_program_done, .local_32m(1'b0),
        .backplane_32m(1'b0), .local_data_word, .backplane_data_word, .data_mem_addr, .local_out_index,
        .backplane_out_index, .local_conn_word, .backplane_conn_word, .output_drive_enable_pin,
        .local_output_reset_state, .backplane_output_reset_state, .local_ext_buffer_ctrl,
        .backplane_ext_buffer_ctrl, .local_serial_idle_high, .local_serial_idle_oe,
        .backplane_serial_idle_high, .backplane_serial_idle_oe);
    cm_host_cpu cm_host_cpu_i (.clk, .rdata, .ack_n(data_transfer_ack_n), .ack_oe(data_transfer_ack_oe),
        .cs_n, .ds_n, .rd_wr_n, .addr, .wdata);
    function automatic logic [15:0] fill(input logic [2:0] p);
        return {p, 13'h0000};
    endfunction
    function automatic logic [11:0] fold(input logic [14:0] a);
        return {a[12:9], a[7:0]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic [2:0] m, input logic r, input logic [14:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        logic ok;
        memory_select <= m;
        @(posedge clk);
        cm_host_cpu_i.access(r, a, d, q, ok);
        chk(ok, 1'b1);
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        // whole run needs about 27500 cycles
        if (cyc == 40000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        logic [15:0] q, d;
        logic [14:0] a;
        logic [5:0]  pat;
        int          k;
        void'($urandom(32'h9092));
        repeat (2) @(posedge clk);
        {local_output_reset_state, backplane_output_reset_state} <= 2'($urandom);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({local_ext_buffer_ctrl, backplane_ext_buffer_ctrl, local_serial_idle_high, backplane_serial_idle_high,
             local_serial_idle_oe, backplane_serial_idle_oe},
            {4'h0, 2'h3, local_output_reset_state, backplane_output_reset_state});
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (12500) @(posedge clk);
        $display("reset test complete");
        {local_block_pattern, backplane_block_pattern} <= 6'($urandom);
        block_mode_bit <= 1'b1;
        @(posedge clk);
        block_program_enable <= 1'b1;
        for (k = 0; k < 5000 && block_program_done !== 1'b1; k++) @(posedge clk);
        chk(block_program_done, 1'b1);
        {block_mode_bit, block_program_enable} <= 2'b00;
        repeat (4) begin
            a = {1'b1, 14'($urandom)};
            acc(3'h0, 1'b1, a, 16'h0000, q);
            chk(q, fill(local_block_pattern));
            acc(3'h1, 1'b1, a, 16'h0000, q);
            chk(q, fill(backplane_block_pattern));
        end
        // a cut fill must leave the far words with the old pattern
        pat = {local_block_pattern, backplane_block_pattern};
        for (k = 0; k < 2; k++) begin
            {local_block_pattern, backplane_block_pattern} <= ~pat;
            block_mode_bit <= 1'b1;
            @(posedge clk);
            block_program_enable <= 1'b1;
            repeat (200) @(posedge clk);
            if (k == 1) block_mode_bit <= 1'b0;
            else block_program_enable <= 1'b0;
            repeat (5000) @(posedge clk);
            chk(block_program_done, 1'b0);
            acc(3'(k), 1'b1, 15'h5E00, 16'h0000, q);
            chk(q, fill((k == 0) ? pat[5:3] : pat[2:0]));
            {block_mode_bit, block_program_enable} <= 2'b00;
            @(posedge clk);
        end
        $display("block fill test complete");
        for (k = 0; k < 8; k++) begin
            a = {1'b1, 14'($urandom)};
            d = 16'($urandom);
            acc(3'(k % 2), 1'b0, a, d, q);
            acc(3'(k % 2), 1'b1, a, 16'h0000, q);
            chk(q, d);
            {local_out_index, backplane_out_index} <= {fold(a), fold(a)};
            repeat (4) @(posedge clk);
            chk((k % 2 == 1) ? backplane_conn_word : local_conn_word, d);
        end
        $display("connection memory test complete");
        for (k = 2; k < 4; k++) begin
            a = {1'b1, 14'($urandom)};
            d = 16'($urandom);
            {local_data_word, backplane_data_word} <= 16'($urandom);
            acc(3'(k - 2), 1'b0, a, d, q);
            acc(3'(k), 1'b0, a, ~d, q);
            acc(3'(k), 1'b1, a, 16'h0000, q);
            chk(q, {8'h00, (k == 2) ? local_data_word : backplane_data_word});
            chk(data_mem_addr, fold(a));
            acc(3'(k - 2), 1'b1, a, 16'h0000, q);
            chk(q, d);
        end
        acc(3'h0, 1'b1, {1'b0, 14'($urandom)}, 16'h0000, q);
        chk(q, 16'h0000);
        // last word written above went to the backplane memory at a
        switch_clock_ok <= 1'b0;
        acc(3'h1, 1'b0, a, ~d, q);
        switch_clock_ok <= 1'b1;
        acc(3'h1, 1'b1, a, 16'h0000, q);
        chk(q, d);
        $display("access rules test complete");
        output_drive_enable_pin <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({local_ext_buffer_ctrl, backplane_ext_buffer_ctrl, local_serial_idle_high, backplane_serial_idle_high},
            6'h3C);
        $display("drive enable test complete");
        test_done();
    end
endmodule
